/* File: core/rpu_params.svh */
// Constants for the ROM patch unit
`ifndef RPU_PARAMS_SVH
`define RPU_PARAMS_SVH
`define RPU_ENTRIES 8
`define RPU_WINDOW_BASE 32'h40008400
`define RPU_WINDOW_MASK 32'hfffffc00
// Entry x: match address at 8*x, replacement word at 8*x+4
`define RPU_OFF_BITS 10
`define RPU_ENTRY_STRIDE 8
`define RPU_DATA_SLOT 4
`define RPU_SLOT_SEL_BIT 2
`define RPU_ENTRY_LSB 3
`define RPU_ENTRY_SPAN 10'h040
`define RPU_OFF_VALID 10'h040
`define RPU_OFF_DISABLE 10'h044
`define RPU_OFF_ENABLE 10'h048
`define RPU_VALID_RESET 8'h00
`define RPU_HTRANS_NONSEQ 2'b10
`define RPU_HTRANS_SEQ 2'b11
`endif

/* File: core/rpu_pkg.sv */
// Types for the ROM patch unit
`include "rpu_params.svh"
package rpu_pkg;
  // One AHB address phase as captured for the data phase
  typedef struct packed {
    logic sel;
    logic write;
    logic [`RPU_OFF_BITS-1:0] offset;
  } rpu_aphase_t;
endpackage

/* File: core/rpu_top.sv */
// ROM patch unit: AHB-Lite register slave and read data substitution
//
// Notes on behaviour
// - Sits in ROM read data path, choosing ROM word or stored replacement per word.
// - Eight entries, each a 32-bit match address then a 32-bit replacement word.
// - Entry valid bit sets itself once its data is written after its address.
// - Bus address compared against all eight match addresses in parallel.
// - On match with an enabled entry, replacement word replaces ROM data.
// - Several matches: highest numbered entry wins.
// - Writing one to a disable bit clears that entry's valid flag.
// - Writing one to an enable bit sets that entry's valid flag again.
// - Configuration registers read and written through an AHB slave port.
// - Runs on the AHB clock; matching and all updates except the asynchronous reset synchronous to it.
// - Registers decoded only inside the 0x40008400 to 0x400087ff window.
`timescale 1ns/100ps
`include "rpu_params.svh"
module rpu_top #(
  parameter int ENTRIES = `RPU_ENTRIES
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HSEL,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic ROM_ACCESS,
  input wire logic [31:0] ROM_RDATA,
  output logic [31:0] PATCHED_RDATA,
  output logic PATCH_HIT
);
  import rpu_pkg::*;

  localparam int IDX_BITS = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // Entry storage, one match address and one replacement word per entry
  logic [31:0] match_addr_reg [ENTRIES];
  logic [31:0] repl_word_reg [ENTRIES];

  // Pairing state: an address write arms the entry, a data write completes it
  logic [ENTRIES-1:0] addr_written_reg;
  logic [ENTRIES-1:0] valid_reg;

  // Pipeline of the register bus and of the ROM read path
  rpu_aphase_t aphase_reg;
  logic [31:0] rom_addr_reg;
  logic rom_read_reg;

  // Strobes of the register data phase now on the bus
  logic transfer;
  logic reg_wr;
  logic reg_rd;
  logic [ENTRIES-1:0] wdata_bits;
  logic [ENTRIES-1:0] addr_wr_vec;
  logic [ENTRIES-1:0] data_wr_vec;
  logic [ENTRIES-1:0] set_vec;
  logic [ENTRIES-1:0] clr_vec;

  // Matching
  logic [ENTRIES-1:0] hit_vec;
  logic [IDX_BITS-1:0] win_idx;
  logic win_any;

  function automatic logic window_hit(input logic [31:0] a);
    return (a & `RPU_WINDOW_MASK) == `RPU_WINDOW_BASE;
  endfunction

  // Offset of the match address of an entry
  function automatic logic [`RPU_OFF_BITS-1:0] addr_slot(input int idx);
    return `RPU_OFF_BITS'(idx * `RPU_ENTRY_STRIDE);
  endfunction

  // Offset of the replacement word of an entry
  function automatic logic [`RPU_OFF_BITS-1:0] data_slot(input int idx);
    return `RPU_OFF_BITS'(idx * `RPU_ENTRY_STRIDE + `RPU_DATA_SLOT);
  endfunction

  // Entry addressed by an offset inside the pair area
  function automatic logic [IDX_BITS-1:0] slot_entry(input logic [`RPU_OFF_BITS-1:0] off);
    return IDX_BITS'(off >> `RPU_ENTRY_LSB);
  endfunction

  // Second word of a pair is the replacement word
  function automatic logic is_data_slot(input logic [`RPU_OFF_BITS-1:0] off);
    return off[`RPU_SLOT_SEL_BIT];
  endfunction

  // Highest set bit wins, so later entries override earlier ones
  function automatic logic [IDX_BITS-1:0] top_hit(input logic [ENTRIES-1:0] v);
    logic [IDX_BITS-1:0] idx;
    idx = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (v[i]) begin
        idx = IDX_BITS'(i);
      end
    end
    return idx;
  endfunction

  assign transfer = HREADY && (HTRANS == `RPU_HTRANS_NONSEQ || HTRANS == `RPU_HTRANS_SEQ);
  assign reg_wr = aphase_reg.sel && aphase_reg.write;
  assign reg_rd = aphase_reg.sel && !aphase_reg.write;
  assign wdata_bits = HWDATA[ENTRIES-1:0];

  // Register slave answers in zero wait states and never errors
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Address phase capture for the register window
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aphase_reg <= '0;
    end else if (HREADY) begin
      aphase_reg.sel <= transfer && HSEL && window_hit(HADDR);
      aphase_reg.write <= HWRITE;
      // Full window offset, so no alias of the pair area elsewhere in the window
      aphase_reg.offset <= HADDR[`RPU_OFF_BITS-1:0];
    end
  end

  // Address of the ROM read now in its data phase
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rom_addr_reg <= '0;
      rom_read_reg <= 1'b0;
    end else if (HREADY) begin
      rom_addr_reg <= HADDR;
      rom_read_reg <= transfer && !HWRITE && ROM_ACCESS;
    end
  end

  // Per-entry write strobes and comparators
  always_comb begin
    addr_wr_vec = '0;
    data_wr_vec = '0;
    set_vec = '0;
    clr_vec = '0;
    hit_vec = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      addr_wr_vec[i] = reg_wr && aphase_reg.offset == addr_slot(i);
      data_wr_vec[i] = reg_wr && aphase_reg.offset == data_slot(i);
      set_vec[i] = reg_wr && aphase_reg.offset == `RPU_OFF_ENABLE && wdata_bits[i];
      clr_vec[i] = reg_wr && aphase_reg.offset == `RPU_OFF_DISABLE && wdata_bits[i];
      // One comparator per entry, all in parallel
      hit_vec[i] = valid_reg[i] && (match_addr_reg[i] == rom_addr_reg);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
      // Entry storage has no reset; contents are lost on power-down anyway
      always_ff @(posedge SYS_CLK) begin
        if (addr_wr_vec[gi]) begin
          match_addr_reg[gi] <= HWDATA;
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (data_wr_vec[gi]) begin
          repl_word_reg[gi] <= HWDATA;
        end
      end

      // A data write without an earlier address write must not arm the entry
      always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          addr_written_reg[gi] <= 1'b0;
        end else if (addr_wr_vec[gi]) begin
          addr_written_reg[gi] <= 1'b1;
        end
      end

      always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          valid_reg[gi] <= 1'b0;
        end else if (addr_wr_vec[gi]) begin
          // Fresh address drops the stale entry until its word follows
          valid_reg[gi] <= 1'b0;
        end else if (data_wr_vec[gi] && addr_written_reg[gi]) begin
          valid_reg[gi] <= 1'b1;
        end else if (set_vec[gi]) begin
          valid_reg[gi] <= 1'b1;
        end else if (clr_vec[gi]) begin
          valid_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Winner of the comparison; only a ROM read in its data phase may use it
  always_comb begin
    win_any = rom_read_reg && (|hit_vec);
    win_idx = top_hit(hit_vec);
  end

  // Combinational so the ROM data is never delayed by a wait state
  always_comb begin
    PATCHED_RDATA = ROM_RDATA;
    PATCH_HIT = 1'b0;
    if (win_any) begin
      PATCHED_RDATA = repl_word_reg[win_idx];
      PATCH_HIT = 1'b1;
    end
  end

  // Register read mux; write-only registers and holes read zero
  always_comb begin
    HRDATA = '0;
    if (reg_rd) begin
      if (aphase_reg.offset < `RPU_ENTRY_SPAN) begin
        if (is_data_slot(aphase_reg.offset)) begin
          HRDATA = repl_word_reg[slot_entry(aphase_reg.offset)];
        end else begin
          HRDATA = match_addr_reg[slot_entry(aphase_reg.offset)];
        end
      end else if (aphase_reg.offset == `RPU_OFF_VALID) begin
        HRDATA[ENTRIES-1:0] = valid_reg;
      end
    end
  end
endmodule // rpu_top

/* File: dv/rpu_top_monitor.sv */
// Port checker for the ROM patch unit
`timescale 1ns/100ps
module rpu_top_monitor (
  input wire logic SYS_CLK, RESET_N, HWRITE, HSEL, HREADY, HREADYOUT, HRESP, ROM_ACCESS, PATCH_HIT,
  input wire logic [1:0] HTRANS,
  input wire logic [31:0] HADDR, HRDATA, ROM_RDATA, PATCHED_RDATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_rdy; HREADYOUT && !HRESP; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state or error");
  property p_pass; !PATCH_HIT |-> PATCHED_RDATA == ROM_RDATA; endproperty
  a_pass: assert property (p_pass) else $error("rom data altered");
  property p_wr; HREADY && HWRITE |=> !PATCH_HIT; endproperty
  a_wr: assert property (p_wr) else $error("write patched");
  property p_rom; HREADY && !ROM_ACCESS |=> !PATCH_HIT; endproperty
  a_rom: assert property (p_rom) else $error("non rom patched");
  property p_idle; HREADY && !HTRANS[1] |=> !PATCH_HIT; endproperty
  a_idle: assert property (p_idle) else $error("idle patched");
  property p_sel; HREADY && !HSEL |=> HRDATA == 0; endproperty
  a_sel: assert property (p_sel) else $error("unselected read data");
  property p_wo; HREADY && HSEL && HTRANS[1] && !HWRITE && HADDR[9:0] inside {10'h044, 10'h048} |=> HRDATA == 0; endproperty
  a_wo: assert property (p_wo) else $error("write-only reg read back");
  property p_rst; $rose(RESET_N) |-> !PATCH_HIT; endproperty
  a_rst: assert property (p_rst) else $error("hit after reset");
endmodule // rpu_top_monitor
bind rpu_top rpu_top_monitor mon (.SYS_CLK, .RESET_N, .HWRITE, .HSEL, .HREADY, .HREADYOUT, .HRESP,
  .ROM_ACCESS, .PATCH_HIT, .HTRANS, .HADDR, .HRDATA, .ROM_RDATA, .PATCHED_RDATA);

/* File: dv/rpu_rom_model.sv */
// ROM read path model
`timescale 1ns/100ps
module rpu_rom_model (
  input wire logic SYS_CLK, HREADY, ROM_ACCESS, HWRITE,
  input wire logic [1:0] HTRANS,
  input wire logic [31:0] HADDR,
  output logic [31:0] ROM_RDATA
);
  logic [31:0] addr_reg;
  logic dp_reg;
  always @(posedge SYS_CLK) begin
    addr_reg <= HADDR;
    dp_reg <= HREADY && ROM_ACCESS && HTRANS[1] && !HWRITE;
  end
  // Outside a data phase show junk, not stale data
  assign ROM_RDATA = dp_reg ? addr_reg ^ 32'h5a5a5a5a : ~addr_reg;
endmodule // rpu_rom_model

/* File: dv/tb.sv */
// Self-checking bench for the ROM patch unit
`timescale 1ns/100ps
module tb;
  localparam logic [31:0] B = 32'h40008400, V = 32'h40008440;
  logic SYS_CLK = 0, RESET_N = 0, HWRITE = 0, HSEL = 0, ROM_ACCESS = 0, rd_dp = 0, PATCH_HIT, HREADYOUT, HRESP;
  logic HREADY = 1;
  logic [1:0] HTRANS = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, wd_p = 0, lf = 32'h52, ra, HRDATA, ROM_RDATA, PATCHED_RDATA;
  logic [33:0] q[$], e;
  int miscompares = 0, n_compared = 0, cyc = 0;
  rpu_top DUT (.SYS_CLK, .RESET_N, .HADDR, .HTRANS, .HWRITE, .HSEL, .HREADY, .HWDATA, .HRDATA,
    .HREADYOUT, .HRESP, .ROM_ACCESS, .ROM_RDATA, .PATCHED_RDATA, .PATCH_HIT);
  rpu_rom_model rom (.SYS_CLK, .HREADY, .ROM_ACCESS, .HWRITE, .HTRANS, .HADDR, .ROM_RDATA);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pipelined: data of a write goes out with the next address phase
  task automatic bus(input logic [31:0] a, d, input logic w, r, input logic [33:0] x);
    @(posedge SYS_CLK);
    {HADDR, HWRITE, ROM_ACCESS, HSEL, HTRANS, HWDATA} <= {a, w, r, !r, 2'b10, wd_p};
    wd_p = d;
    if (!w) q.push_back(x);
  endtask
  task end_sim;
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial forever #25 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) rd_dp <= HTRANS[1] && !HWRITE && RESET_N;
  always @(negedge SYS_CLK) if (rd_dp) begin
    e = q.pop_front();
    n_compared++;
    if ((e[33] ? {PATCH_HIT, PATCHED_RDATA} : {1'b0, HRDATA}) !== e[32:0]) begin
      miscompares++;
      $display("wrong value at %0t: got %h %h want %h", $time, PATCHED_RDATA, HRDATA, e);
    end
  end
  always @(posedge SYS_CLK) if (++cyc > 3000) begin
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET_N <= 1;
    bus(V, 0, 0, 0, 34'h0);
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf);
      ra = {16'h0001, lf[15:2], 2'b00};
      bus(ra, 0, 0, 1, {2'b10, ra ^ 32'h5a5a5a5a});
    end
    for (int j = 0; j < 8; j++) begin
      bus(B + 8 * j, (j == 2 || j == 5) ? 32'h3000 : 32'h100 + 4 * j, 1, 0, 0);
      bus(B + 8 * j + 4, 32'hd0 + j, 1, 0, 0);
    end
    bus(V, 0, 0, 0, 34'hff);
    bus(B + 24, 0, 0, 0, 34'h10c);
    bus(32'h3000, 0, 0, 1, {2'b11, 32'hd5});
    bus(32'h104, 0, 0, 1, {2'b11, 32'hd1});
    bus(B + 32'h44, 32'h20, 1, 0, 0);
    bus(V, 0, 0, 0, 34'hdf);
    bus(32'h3000, 0, 0, 1, {2'b11, 32'hd2});
    bus(B + 32'h48, 32'h20, 1, 0, 0);
    bus(V, 0, 1, 0, 0);
    bus(V, 0, 0, 0, 34'hff);
    bus(B + 32'h44, 0, 0, 0, 34'h0);
    bus(B + 32'h4c, 0, 0, 0, 34'h0);
    @(posedge SYS_CLK) HTRANS <= 2'b00;
    // Phase shown while HREADY is low must not be taken, then taken once high
    bus(32'h3000, 0, 0, 1, {2'b10, ~32'h3000});
    HREADY <= 1'b0;
    q.push_back({2'b11, 32'hd5});
    @(posedge SYS_CLK) HREADY <= 1'b1;
    @(posedge SYS_CLK) HTRANS <= 2'b00;
    repeat (2) @(posedge SYS_CLK);
    end_sim();
  end
endmodule // tb
